/* File: hdl/fcs_top.sv */
`timescale 1ns/10ps
`include "fcs_defines.svh"
// Functional notes
// RULE_01 - Written bytes decoded as commands, not stored
// RULE_02 - Bad byte or gap time-out returns read
// RULE_03 - Commands start AAh@555h then 55h@AAAh
// RULE_04 - Upper address ignored; select needed per write
// RULE_05 - Main selects pick primary, boot secondary
// RULE_06 - Identifier read only on primary array
// RULE_07 - Reset enters read; lockout blocks writes
// RULE_08 - Host keeps strobe high during power-up
// RULE_09 - Plain reads return array data
// RULE_10 - Identifier read at address bits 001
// RULE_11 - Protection read at 010 gives 01h/00h
// RULE_12 - Busy reads return status, repeatable
// RULE_13 - Programming shows inverted bit seven
// RULE_14 - Status valid after fourth or sixth write
// RULE_15 - Erase shows poll bit zero
// RULE_16 - Program to protected sector ignored
// RULE_17 - All-protected erase fakes busy for 100us
// RULE_18 - Toggle bit flips per selected status read
// RULE_19 - Error bit set on failure or 0-to-1
// RULE_20 - Error bit cleared only by reset command
// RULE_21 - Erase window bit low 120us after erase; code sets it high at once on each added sector command
// RULE_22 - Status bit layout 7,6,5,3; others zero
// RULE_23 - Only low twelve address bits decoded
// RULE_24 - Reset command leaves identifier or error mode
// RULE_25 - Inter-byte time-out is a parameter count
module fcs_top
    import fcs_pkg::*;
#(
    parameter logic [7:0] ID_CODE = 8'h5A, // Arbitrary identifier value
    parameter int INTERBYTE_CYC = `FCS_INTERBYTE_CYC,
    parameter int ERASE_WIN_CYC = `FCS_ERASE_WIN_CYC,
    parameter int PROT_ERASE_CYC = `FCS_PROT_ERASE_CYC
) (
    input wire logic clk,
    input wire logic rst,
    input wire fcs_bus_s bus,
    input wire logic storePulseN,
    input wire logic rdStrobe,
    input wire logic [7:0] arrayData,
    input wire logic [7:0] mainProt,
    input wire logic [3:0] bootProt,
    input wire logic belowLockout,
    input wire logic opDone,
    input wire logic opFail,
    output logic [7:0] rdData,
    output logic rdValid,
    output fcs_op_s op,
    output logic readMode,
    output logic errorFlag
);
    localparam int TW = 12;

    fcs_state_e state_r, state_nxt;
    fcs_op_s op_r, op_nxt;
    logic strobePrev_r;
    logic arrBoot_r, arrBoot_nxt;
    logic erasing_r, erasing_nxt;
    logic progBit7_r, progBit7_nxt;
    logic err_r, err_nxt;
    logic winFlag_r, winFlag_nxt;
    logic tog_r, tog_nxt;
    logic [7:0] rdData_r, rdData_nxt;
    logic rdValid_r, rdValid_nxt;

    logic wrEv, anySel, wrOk, isBoot, sameArr, selProt;
    logic [11:0] a12, curMask, protMask, eraseMask;
    logic [7:0] wd;
    logic [2:0] idSel;
    logic errSet, errClr;
    logic ibStart, winStart, protStart, finishErase;
    logic ibExpire, winExpire, protExpire;
    logic statusMode;

    // A write counts at the rising edge of the active-low store pulse
    assign wrEv = storePulseN & ~strobePrev_r & ~belowLockout; // [RULE_07]
    assign anySel = (|bus.mainSel) | (|bus.bootSel);
    assign wrOk = wrEv & anySel; // [RULE_04]
    assign isBoot = ~(|bus.mainSel) & (|bus.bootSel); // [RULE_05]
    assign sameArr = (isBoot == arrBoot_r);
    assign a12 = bus.addr[11:0]; // [RULE_23] [RULE_04]
    assign wd = bus.data;
    assign curMask = {bus.bootSel, bus.mainSel};
    assign protMask = {bootProt, mainProt};
    assign selProt = |(curMask & protMask);
    assign idSel = {bus.addr[6], bus.addr[1], bus.addr[0]};
    assign statusMode = (state_r == FCS_ERWIN) || (state_r == FCS_BUSY) ||
        (state_r == FCS_PROTER) || (state_r == FCS_ERROR);

    fcs_timer #(.W(TW)) u_ibTimer (
        .clk(clk),
        .rst(rst),
        .start(ibStart),
        .load(TW'(INTERBYTE_CYC)),
        .running(),
        .expire(ibExpire)
    );

    fcs_timer #(.W(TW)) u_winTimer (
        .clk(clk),
        .rst(rst),
        .start(winStart),
        .load(TW'(ERASE_WIN_CYC)),
        .running(),
        .expire(winExpire)
    );

    fcs_timer #(.W(TW)) u_protTimer (
        .clk(clk),
        .rst(rst),
        .start(protStart),
        .load(TW'(PROT_ERASE_CYC)),
        .running(),
        .expire(protExpire)
    );

    always_comb begin
        state_nxt = state_r;
        op_nxt = op_r;
        op_nxt.prog = 1'b0;
        op_nxt.sectErase = 1'b0;
        op_nxt.bulkErase = 1'b0;
        arrBoot_nxt = arrBoot_r;
        erasing_nxt = erasing_r;
        progBit7_nxt = progBit7_r;
        winFlag_nxt = winFlag_r;
        ibStart = 1'b0;
        winStart = 1'b0;
        protStart = 1'b0;
        finishErase = 1'b0;
        errSet = opFail; // [RULE_19]
        errClr = 1'b0;
        eraseMask = op_r.sectMask;
        case (state_r)
            FCS_READ: begin
                if (wrOk && wd == `FCS_UNLOCK1_DATA &&
                    a12 == `FCS_UNLOCK1_ADDR) begin // [RULE_03] [RULE_01]
                    state_nxt = FCS_UNL1;
                    arrBoot_nxt = isBoot; // [RULE_05]
                    ibStart = 1'b1;
                end
            end
            FCS_UNL1: begin
                if (wrOk) begin
                    ibStart = 1'b1;
                    if (sameArr && wd == `FCS_UNLOCK2_DATA &&
                        a12 == `FCS_UNLOCK2_ADDR) begin // [RULE_03]
                        state_nxt = FCS_UNL2;
                    end else begin
                        state_nxt = FCS_READ; // [RULE_02]
                    end
                end else if (ibExpire) begin
                    state_nxt = FCS_READ; // [RULE_02] [RULE_25]
                end
            end
            FCS_UNL2: begin
                if (wrOk) begin
                    ibStart = 1'b1;
                    state_nxt = FCS_READ; // [RULE_02]
                    if (sameArr && a12 == `FCS_UNLOCK1_ADDR) begin
                        case (wd)
                            `FCS_OP_RESET: errClr = 1'b1; // [RULE_20]
                            `FCS_OP_IDENT: state_nxt = FCS_IDENT;
                            `FCS_OP_PROGRAM: state_nxt = FCS_PGM;
                            `FCS_OP_ERASE: state_nxt = FCS_ER1;
                            default: state_nxt = FCS_READ;
                        endcase
                    end
                end else if (ibExpire) begin
                    state_nxt = FCS_READ; // [RULE_02] [RULE_25]
                end
            end
            FCS_IDENT: begin
                if (wrOk && wd == `FCS_OP_RESET) begin
                    state_nxt = FCS_READ; // [RULE_24]
                end
            end
            FCS_PGM: begin
                if (wrOk) begin
                    if (!sameArr || selProt) begin
                        state_nxt = FCS_READ; // [RULE_16]
                    end else if (|(wd & ~arrayData)) begin
                        errSet = 1'b1; // [RULE_19]
                        erasing_nxt = 1'b0;
                        progBit7_nxt = wd[7];
                        state_nxt = FCS_ERROR;
                    end else begin
                        op_nxt.prog = 1'b1; // [RULE_01]
                        op_nxt.bootArray = arrBoot_r;
                        op_nxt.addr = bus.addr;
                        op_nxt.data = wd;
                        op_nxt.sectMask = curMask;
                        erasing_nxt = 1'b0;
                        progBit7_nxt = wd[7]; // [RULE_13]
                        state_nxt = FCS_BUSY; // [RULE_14]
                    end
                end else if (ibExpire) begin
                    state_nxt = FCS_READ; // [RULE_02]
                end
            end
            FCS_ER1: begin
                if (wrOk) begin
                    ibStart = 1'b1;
                    state_nxt = (sameArr && wd == `FCS_UNLOCK1_DATA &&
                        a12 == `FCS_UNLOCK1_ADDR) ? FCS_ER2 : FCS_READ;
                end else if (ibExpire) begin
                    state_nxt = FCS_READ; // [RULE_02]
                end
            end
            FCS_ER2: begin
                if (wrOk) begin
                    ibStart = 1'b1;
                    state_nxt = (sameArr && wd == `FCS_UNLOCK2_DATA &&
                        a12 == `FCS_UNLOCK2_ADDR) ? FCS_ER3 : FCS_READ;
                end else if (ibExpire) begin
                    state_nxt = FCS_READ; // [RULE_02]
                end
            end
            FCS_ER3: begin
                if (wrOk) begin
                    state_nxt = FCS_READ; // [RULE_02]
                    if (sameArr && wd == `FCS_OP_BULK &&
                        a12 == `FCS_UNLOCK1_ADDR) begin
                        eraseMask = arrBoot_r ? `FCS_BOOT_MASK :
                            `FCS_MAIN_MASK;
                        op_nxt.sectMask = eraseMask;
                        op_nxt.bootArray = arrBoot_r;
                        op_nxt.addr = bus.addr;
                        finishErase = 1'b1;
                    end else if (sameArr && wd == `FCS_OP_SECTOR) begin
                        op_nxt.sectMask = curMask;
                        op_nxt.bootArray = arrBoot_r;
                        op_nxt.addr = bus.addr;
                        erasing_nxt = 1'b1;
                        winStart = 1'b1;
                        winFlag_nxt = 1'b0; // [RULE_21]
                        state_nxt = FCS_ERWIN;
                    end
                end else if (ibExpire) begin
                    state_nxt = FCS_READ; // [RULE_02]
                end
            end
            FCS_ERWIN: begin
                if (wrOk) begin
                    if (sameArr && wd == `FCS_OP_SECTOR) begin
                        op_nxt.sectMask = op_r.sectMask | curMask;
                        winStart = 1'b1;
                        winFlag_nxt = 1'b1; // [RULE_21]
                    end else begin
                        state_nxt = FCS_READ; // [RULE_02]
                    end
                end else if (winExpire) begin
                    winFlag_nxt = 1'b1; // [RULE_21]
                    finishErase = 1'b1;
                end
            end
            FCS_BUSY: begin
                if (opDone) begin
                    state_nxt = (err_r || opFail) ? FCS_ERROR : FCS_READ;
                end
            end
            FCS_PROTER: begin
                if (protExpire) begin
                    state_nxt = FCS_READ; // [RULE_17]
                end
            end
            FCS_ERROR: begin
                if (wrOk && wd == `FCS_OP_RESET) begin
                    errClr = 1'b1; // [RULE_20] [RULE_24]
                    state_nxt = FCS_READ;
                end
            end
            default: state_nxt = FCS_READ;
        endcase
        if (finishErase) begin
            erasing_nxt = 1'b1;
            winFlag_nxt = 1'b1;
            if (~|(eraseMask & ~protMask)) begin
                protStart = 1'b1; // [RULE_17]
                state_nxt = FCS_PROTER;
            end else begin
                op_nxt.sectErase = (state_r == FCS_ERWIN);
                op_nxt.bulkErase = (state_r == FCS_ER3);
                state_nxt = FCS_BUSY; // [RULE_14]
            end
        end
        // A failure arriving with the reset command still sets the flag
        err_nxt = (err_r & ~errClr) | errSet; // [RULE_19] [RULE_20]
    end

    always_comb begin
        rdData_nxt = rdData_r;
        rdValid_nxt = 1'b0;
        tog_nxt = tog_r;
        if (rdStrobe) begin
            rdValid_nxt = 1'b1;
            if (statusMode) begin
                rdData_nxt = 8'h00; // [RULE_22]
                rdData_nxt[`FCS_POLL_BIT] = erasing_r ? 1'b0 :
                    ~progBit7_r; // [RULE_13] [RULE_15] [RULE_12]
                rdData_nxt[`FCS_TOGGLE_BIT] = tog_r;
                rdData_nxt[`FCS_ERROR_BIT] = err_r; // [RULE_19]
                rdData_nxt[`FCS_WINDOW_BIT] = winFlag_r; // [RULE_21]
                if (anySel) begin
                    tog_nxt = ~tog_r; // [RULE_18]
                end
            end else if (state_r == FCS_IDENT && idSel == `FCS_ID_SEL_IDENT
                && |bus.mainSel) begin
                rdData_nxt = ID_CODE; // [RULE_10] [RULE_06]
            end else if (state_r == FCS_IDENT &&
                idSel == `FCS_ID_SEL_PROT) begin
                rdData_nxt = selProt ? `FCS_PROT_YES :
                    `FCS_PROT_NO; // [RULE_11]
            end else begin
                rdData_nxt = arrayData; // [RULE_09]
            end
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state_r <= FCS_READ; // [RULE_07] [RULE_09]
            op_r <= '0;
            strobePrev_r <= 1'b1; // [RULE_08]
            arrBoot_r <= 1'b0;
            erasing_r <= 1'b0;
            progBit7_r <= 1'b0;
            err_r <= 1'b0;
            winFlag_r <= 1'b1;
            tog_r <= 1'b0;
            rdData_r <= 8'h00;
            rdValid_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            op_r <= op_nxt;
            strobePrev_r <= storePulseN;
            arrBoot_r <= arrBoot_nxt;
            erasing_r <= erasing_nxt;
            progBit7_r <= progBit7_nxt;
            err_r <= err_nxt;
            winFlag_r <= winFlag_nxt;
            tog_r <= tog_nxt;
            rdData_r <= rdData_nxt;
            rdValid_r <= rdValid_nxt;
        end
    end

    assign rdData = rdData_r;
    assign rdValid = rdValid_r;
    assign op = op_r;
    assign readMode = (state_r == FCS_READ);
    assign errorFlag = err_r;
endmodule

/* File: common/fcs_defines.svh */
`ifndef FCS_DEFINES_SVH
`define FCS_DEFINES_SVH

`define FCS_CLK_HZ 10000000
`define FCS_CYC_PER_US (`FCS_CLK_HZ / 1000000)

`define FCS_UNLOCK1_ADDR 12'h0555
`define FCS_UNLOCK2_ADDR 12'h0AAA
`define FCS_UNLOCK1_DATA 8'hAA
`define FCS_UNLOCK2_DATA 8'h55

`define FCS_OP_RESET 8'hF0
`define FCS_OP_IDENT 8'h90
`define FCS_OP_PROGRAM 8'hA0
`define FCS_OP_ERASE 8'h80
`define FCS_OP_BULK 8'h10
`define FCS_OP_SECTOR 8'h30

`define FCS_ID_SEL_IDENT 3'h1
`define FCS_ID_SEL_PROT 3'h2
`define FCS_PROT_YES 8'h01
`define FCS_PROT_NO 8'h00

`define FCS_MAIN_MASK 12'h00FF
`define FCS_BOOT_MASK 12'h0F00

`define FCS_POLL_BIT 7
`define FCS_TOGGLE_BIT 6
`define FCS_ERROR_BIT 5
`define FCS_WINDOW_BIT 3

`define FCS_ERASE_WIN_US 100
`define FCS_ERASE_WIN_PCT 20
`define FCS_ERASE_WIN_CYC ((`FCS_ERASE_WIN_US * (100 + `FCS_ERASE_WIN_PCT) \
    * `FCS_CYC_PER_US) / 100)
`define FCS_PROT_ERASE_US 100
`define FCS_PROT_ERASE_CYC (`FCS_PROT_ERASE_US * `FCS_CYC_PER_US)
`define FCS_INTERBYTE_US 80
`define FCS_INTERBYTE_CYC (`FCS_INTERBYTE_US * `FCS_CYC_PER_US)

`endif

/* File: common/fcs_pkg.sv */
package fcs_pkg;

    typedef enum logic [3:0] {
        FCS_READ = 4'h0,
        FCS_UNL1 = 4'h1,
        FCS_UNL2 = 4'h2,
        FCS_IDENT = 4'h3,
        FCS_PGM = 4'h4,
        FCS_ER1 = 4'h5,
        FCS_ER2 = 4'h6,
        FCS_ER3 = 4'h7,
        FCS_ERWIN = 4'h8,
        FCS_BUSY = 4'h9,
        FCS_PROTER = 4'hA,
        FCS_ERROR = 4'hB
    } fcs_state_e;

    typedef struct packed {
        logic [15:0] addr;
        logic [7:0] data;
        logic [7:0] mainSel;
        logic [3:0] bootSel;
    } fcs_bus_s;

    typedef struct packed {
        logic prog;
        logic sectErase;
        logic bulkErase;
        logic bootArray;
        logic [15:0] addr;
        logic [7:0] data;
        logic [11:0] sectMask;
    } fcs_op_s;

endpackage

/* File: hdl/fcs_timer.sv */
`timescale 1ns/10ps
module fcs_timer #(
    parameter int W = 12
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic start,
    input wire logic [W-1:0] load,
    output logic running,
    output logic expire
);
    logic [W-1:0] cnt_r, cnt_nxt;
    logic run_r, run_nxt;
    logic exp_r, exp_nxt;

    always_comb begin
        cnt_nxt = cnt_r;
        run_nxt = run_r;
        exp_nxt = 1'b0;
        if (start) begin
            cnt_nxt = load;
            run_nxt = 1'b1;
        end else if (run_r) begin
            if (cnt_r <= {{(W-1){1'b0}}, 1'b1}) begin
                run_nxt = 1'b0;
                exp_nxt = 1'b1;
            end else begin
                cnt_nxt = cnt_r - {{(W-1){1'b0}}, 1'b1};
            end
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cnt_r <= '0;
            run_r <= 1'b0;
            exp_r <= 1'b0;
        end else begin
            cnt_r <= cnt_nxt;
            run_r <= run_nxt;
            exp_r <= exp_nxt;
        end
    end

    assign running = run_r;
    assign expire = exp_r;
endmodule

/* File: testbench/fcs_monitor.sv */
`timescale 1ns/10ps
`include "fcs_defines.svh"
module fcs_monitor
    import fcs_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire fcs_bus_s bus,
    input wire logic storePulseN,
    input wire logic rdStrobe,
    input wire logic [7:0] arrayData,
    input wire logic belowLockout,
    input wire logic opFail,
    input wire logic [7:0] rdData,
    input wire logic rdValid,
    input wire fcs_op_s op,
    input wire logic readMode,
    input wire logic errorFlag
);
    logic prevN_r;
    logic prevN_nxt;
    logic edgeW;
    logic anySel;
    logic wrOk;
    logic wrF0;
    logic isUnl;
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    // Strobe history starts high, as the design's does
    always_comb begin
        prevN_nxt = storePulseN;
    end
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            prevN_r <= 1'b1;
        end else begin
            prevN_r <= prevN_nxt;
        end
    end
    assign edgeW = storePulseN && !prevN_r;
    assign anySel = (|bus.mainSel) || (|bus.bootSel);
    assign wrOk = edgeW && !belowLockout && anySel;
    assign wrF0 = edgeW && bus.data == `FCS_OP_RESET;
    assign isUnl = bus.data == `FCS_UNLOCK1_DATA
        && bus.addr[11:0] == `FCS_UNLOCK1_ADDR;
    a_read_answer: assert property (rdStrobe |=> rdValid)
        else $error("read not answered next cycle");
    a_read_quiet: assert property (!rdStrobe |=> !rdValid)
        else $error("read valid without request");
    a_array_read: assert property (
        rdStrobe && readMode |=> rdData == $past(arrayData))
        else $error("read mode did not return array data");
    a_lockout_hold: assert property (
        readMode && edgeW && belowLockout |=> readMode)
        else $error("write taken below lockout");
    a_unsel_hold: assert property (
        readMode && edgeW && !anySel |=> readMode)
        else $error("write taken without select");
    a_bad_unlock: assert property (
        readMode && wrOk && !isUnl |=> readMode)
        else $error("wrong first cycle left read mode");
    a_unlock_take: assert property (
        readMode && wrOk && isUnl |=> !readMode)
        else $error("first coded cycle not taken");
    a_prog_pulse: assert property (
        op.prog |-> !readMode ##1 !op.prog)
        else $error("program start not a single pulse");
    a_fail_sets: assert property (opFail |=> errorFlag)
        else $error("failure did not set error flag");
    a_err_clear: assert property (
        $fell(errorFlag) |-> $past(wrF0))
        else $error("error flag cleared without reset byte");
endmodule

bind fcs_top fcs_monitor fcs_monitor_i (.clk(clk), .rst(rst), .bus(bus),
    .storePulseN(storePulseN), .rdStrobe(rdStrobe), .arrayData(arrayData),
    .belowLockout(belowLockout), .opFail(opFail), .rdData(rdData),
    .rdValid(rdValid), .op(op), .readMode(readMode),
    .errorFlag(errorFlag));

/* File: testbench/fcs_engine_model.sv */
`timescale 1ns/10ps
module fcs_engine_model
    import fcs_pkg::*;
#(
    parameter int BUSY_CYC = 40
) (
    input wire logic clk,
    input wire logic rst,
    input wire fcs_op_s op,
    input wire logic [15:0] addr,
    input wire logic failReq,
    output logic [7:0] arrayData,
    output logic opDone,
    output logic opFail
);
    logic [7:0] mem [16];
    int cnt;
    fcs_op_s job;
    // Small array image; only the low address nibble selects a byte
    assign arrayData = mem[addr[3:0]];
    always @(posedge clk or posedge rst) begin
        opDone <= 1'b0;
        opFail <= 1'b0;
        if (rst) begin
            cnt <= 0;
            foreach (mem[i]) mem[i] <= 8'hFF;
        end else if (op.prog || op.sectErase || op.bulkErase) begin
            job <= op;
            cnt <= BUSY_CYC;
        end else if (cnt == 1) begin
            cnt <= 0;
            opDone <= 1'b1;
            opFail <= failReq;
            if (job.prog) begin
                // Programming can only clear bits
                mem[job.addr[3:0]] <= mem[job.addr[3:0]] & job.data;
            end else begin
                foreach (mem[i]) mem[i] <= 8'hFF;
            end
        end else if (cnt > 1) begin
            cnt <= cnt - 1;
        end
    end
endmodule

/* File: testbench/fcs_tb_top.sv */
`timescale 1ns/10ps
`include "fcs_defines.svh"
module fcs_tb_top
    import fcs_pkg::*;
;
    localparam int IB = 20;
    localparam int EW = 30;
    localparam int PE = 25;
    localparam logic [7:0] ID = 8'h3C; // Arbitrary identifier value
    logic clk, rst, storePulseN, rdStrobe, belowLockout, failReq;
    logic opDone, opFail, rdValid, readMode, errorFlag;
    logic [7:0] mainProt, arrayData, rdData, d0, d1;
    logic [3:0] bootProt;
    fcs_bus_s bus;
    fcs_op_s op;
    int mismatches, n_tests, n;
    fcs_top #(.ID_CODE(ID), .INTERBYTE_CYC(IB), .ERASE_WIN_CYC(EW),
        .PROT_ERASE_CYC(PE)) fcs_top_i (.clk(clk), .rst(rst), .bus(bus),
        .storePulseN(storePulseN), .rdStrobe(rdStrobe),
        .arrayData(arrayData), .mainProt(mainProt), .bootProt(bootProt),
        .belowLockout(belowLockout), .opDone(opDone), .opFail(opFail),
        .rdData(rdData), .rdValid(rdValid), .op(op), .readMode(readMode),
        .errorFlag(errorFlag));
    fcs_engine_model fcs_engine_model_i (.clk(clk), .rst(rst), .op(op),
        .addr(bus.addr), .failReq(failReq), .arrayData(arrayData),
        .opDone(opDone), .opFail(opFail));
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    task automatic chk(input string nm, input logic [7:0] e,
        input logic [7:0] g);
        n_tests++;
        if (g !== e) begin
            $display("[ERR] %s expected %h seen %h", nm, e, g);
            mismatches++;
        end
    endtask
    task automatic end_sim();
        $display("tests %0d mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    task automatic sel(input logic [7:0] m, input logic [3:0] b,
        input logic [7:0] pm);
        @(posedge clk);
        bus.mainSel <= m;
        bus.bootSel <= b;
        mainProt <= pm;
    endtask
    // Strobe low for two cycles; the byte is taken on the rise
    task automatic wr(input logic [15:0] a, input logic [7:0] dt);
        @(posedge clk);
        bus.addr <= a;
        bus.data <= dt;
        storePulseN <= 1'b0;
        repeat (2) @(posedge clk);
        storePulseN <= 1'b1;
        repeat (2) @(posedge clk);
        #1;
    endtask
    task automatic rd(input logic [15:0] a, output logic [7:0] d);
        @(posedge clk);
        bus.addr <= a;
        rdStrobe <= 1'b1;
        @(posedge clk);
        rdStrobe <= 1'b0;
        #1;
        chk("rdValid", 8'h01, {7'h00, rdValid});
        d = rdData;
    endtask
    task automatic cmd(input logic [7:0] c);
        wr(16'h7555, `FCS_UNLOCK1_DATA);
        wr(16'hBAAA, `FCS_UNLOCK2_DATA);
        if (c != 8'h00) wr(16'h3555, c);
    endtask
    task automatic waitRead();
        n = 0;
        while (readMode !== 1'b1 && n < 300) begin
            @(posedge clk);
            #1;
            n++;
        end
        chk("readMode", 8'h01, {7'h00, readMode});
    endtask
    task automatic done(input string s);
        $display("test %s end", s);
    endtask
    initial begin
        #2_000_000;
        mismatches++;
        end_sim();
    end
    initial begin
        rst = 1'b1;
        storePulseN = 1'b1;
        bus = '0;
        rdStrobe = 1'b0;
        belowLockout = 1'b0;
        failReq = 1'b0;
        mainProt = 8'h00;
        bootProt = 4'h0;
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        #1;
        chk("resetRead", 8'h01, {7'h00, readMode});
        chk("resetErr", 8'h00, {7'h00, errorFlag});
        sel(8'h01, 4'h0, 8'h00);
        rd(16'h0003, d0);
        chk("array", 8'hFF, d0);
        @(posedge clk) belowLockout <= 1'b1;
        wr(16'h0555, 8'hAA);
        chk("lockout", 8'h01, {7'h00, readMode});
        @(posedge clk) belowLockout <= 1'b0;
        sel(8'h00, 4'h0, 8'h00);
        wr(16'h0555, 8'hAA);
        chk("noSel", 8'h01, {7'h00, readMode});
        sel(8'h01, 4'h0, 8'h00);
        wr(16'hE555, 8'hAA);
        chk("unlock", 8'h00, {7'h00, readMode});
        repeat (IB + 5) @(posedge clk);
        #1;
        chk("gap", 8'h01, {7'h00, readMode});
        cmd(8'h00);
        wr(16'h0555, 8'h56);
        chk("badByte", 8'h01, {7'h00, readMode});
        done("decode");
        cmd(`FCS_OP_IDENT);
        rd(16'hF001, d0);
        chk("ident", ID, d0);
        sel(8'h02, 4'h0, 8'h02);
        rd(16'h0002, d0);
        chk("prot", `FCS_PROT_YES, d0);
        sel(8'h00, 4'h1, 8'h02);
        rd(16'h0002, d0);
        chk("unprot", `FCS_PROT_NO, d0);
        wr(16'h0555, `FCS_OP_RESET);
        chk("leave", 8'h01, {7'h00, readMode});
        cmd(`FCS_OP_IDENT);
        rd(16'h0001, d0);
        chk("bootId", 8'hFF, d0);
        wr(16'h0555, `FCS_OP_RESET);
        done("ident");
        sel(8'h01, 4'h0, 8'h00);
        cmd(`FCS_OP_PROGRAM);
        wr(16'hC003, 8'h5F);
        chk("opData", 8'h5F, op.data);
        rd(16'h0003, d0);
        rd(16'h0003, d1);
        chk("poll", 8'h88, d0 & 8'hBF);
        chk("toggle", 8'h40, (d0 ^ d1) & 8'h40);
        waitRead();
        rd(16'h0003, d0);
        chk("stored", 8'h5F, d0);
        sel(8'h01, 4'h0, 8'h01);
        cmd(`FCS_OP_PROGRAM);
        wr(16'h0004, 8'h00);
        chk("protPgm", 8'h01, {7'h00, readMode});
        rd(16'h0004, d0);
        chk("protData", 8'hFF, d0);
        done("program");
        sel(8'h01, 4'h0, 8'h00);
        cmd(`FCS_OP_PROGRAM);
        wr(16'h0003, 8'hFF);
        chk("err", 8'h01, {7'h00, errorFlag});
        rd(16'h0003, d0);
        chk("errBit", 8'h20, d0 & 8'h20);
        wr(16'h0555, 8'hAA);
        chk("sticky", 8'h01, {7'h00, errorFlag});
        wr(16'h0555, `FCS_OP_RESET);
        chk("clear", 8'h00, {7'h00, errorFlag});
        @(posedge clk) failReq <= 1'b1;
        cmd(`FCS_OP_PROGRAM);
        wr(16'h0005, 8'h00);
        n = 0;
        while (errorFlag !== 1'b1 && n < 300) begin
            @(posedge clk);
            #1;
            n++;
        end
        chk("fail", 8'h01, {7'h00, errorFlag});
        @(posedge clk) failReq <= 1'b0;
        wr(16'h0555, `FCS_OP_RESET);
        chk("errExit", 8'h01, {7'h00, readMode});
        done("error");
        sel(8'h02, 4'h0, 8'h00);
        cmd(`FCS_OP_ERASE);
        cmd(8'h00);
        wr(16'h0000, `FCS_OP_SECTOR);
        rd(16'h0000, d0);
        chk("erWin", 8'h00, d0 & 8'hBF);
        sel(8'h04, 4'h0, 8'h00);
        wr(16'h0000, `FCS_OP_SECTOR);
        rd(16'h0000, d0);
        chk("erMore", 8'h08, d0 & 8'hBF);
        waitRead();
        chk("mask", 8'h06, op.sectMask[7:0]);
        rd(16'h0003, d0);
        chk("erased", 8'hFF, d0);
        sel(8'h01, 4'h0, 8'h01);
        cmd(`FCS_OP_ERASE);
        cmd(8'h00);
        wr(16'h0000, `FCS_OP_SECTOR);
        rd(16'h0000, d0);
        chk("protEr", 8'h00, d0 & 8'h80);
        waitRead();
        chk("protWait", 8'h01, {7'h00, n > EW + PE - 10});
        sel(8'h00, 4'h2, 8'h00);
        cmd(`FCS_OP_ERASE);
        cmd(`FCS_OP_BULK);
        chk("bulkBusy", 8'h00, {7'h00, readMode});
        chk("bulkArr", 8'h01, {7'h00, op.bootArray});
        chk("bulkMask", 8'h0F, {4'h0, op.sectMask[11:8]});
        waitRead();
        done("erase");
        end_sim();
    end
endmodule
